// >>> sbc_defines.svh
// timing, register map and field constants for the mode controller
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define RESET_TIME_NS 4000000
`define SEL_WINDOW_NS 3200
`define SEL_WINDOW_CYCLES (`SEL_WINDOW_NS / `CLK_PERIOD_NS)
`define DOM_TIMEOUT_CYCLES 500000
`define TMR_W 20

// ----------------------------------------------------------------
// register map (byte offsets, 32-bit words)
// ----------------------------------------------------------------
`define ADR_W 4
`define REG_STATUS 4'h0
`define REG_WAKE_TIME 4'h4
`define WAKE_TIME_RESET 32'h2710_2710

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ST_MODE_LSB 0
`define ST_SRC_LSB 2
`define ST_RST_BIT 4
`define ST_TMO_BIT 5
`define WT_BUS_LSB 0
`define WT_LOCAL_LSB 16
`define WT_FIELD_W 16

// ----------------------------------------------------------------
// input synchroniser vector
// ----------------------------------------------------------------
`define SYNC_W 10
`define SYNC_RESET 10'h000

`endif

// >>> sbc_pkg.sv
// types shared by the mode controller
package sbc_pkg;

   // ----------------------------------------------------------------
   // operating modes and fail-safe sources
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FAILSAFE,
      MODE_NORMAL,
      MODE_SILENT,
      MODE_SLEEP
   } mode_e;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_BUS,
      SRC_LOCAL,
      SRC_BATTERY
   } source_e;

endpackage

// >>> lin_sbc_mode_controller.sv
// operating-mode controller of a lin system basis chip with wishbone access
`timescale 1ns/1ps
`include "sbc_defines.svh"

module lin_sbc_mode_controller
   import sbc_pkg::*;
#(
   parameter int unsigned RESET_CYCLES = `RESET_TIME_NS / `CLK_PERIOD_NS,
   parameter int unsigned DOM_CYCLES = `DOM_TIMEOUT_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [`ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // host pins
   input wire logic enable_pin,
   input wire logic txd_in,
   output logic txd_out,
   output logic txd_oe,
   output logic rxd,
   input wire logic undervoltage_reset_in_n,
   output logic undervoltage_reset_out_n,
   output logic undervoltage_reset_oe,
   input wire logic [1:0] low_side_control_in,
   output logic [1:0] low_side_out,
   // bus front end and supply monitors
   input wire logic bus_level,
   input wire logic bus_prewake_threshold,
   input wire logic local_wake_input,
   input wire logic vcc_undervoltage,
   input wire logic battery_undervoltage_threshold,
   output logic transceiver_tx_enable,
   output logic transceiver_rx_enable,
   output logic bus_drive_dominant,
   output logic bus_receiver_enable,
   output logic slave_termination_enable,
   output logic weak_pullup_enable,
   output logic regulator_enable
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [`SYNC_W-1:0] raw_in;
   logic [`SYNC_W-1:0] meta_q;
   logic [`SYNC_W-1:0] sync_q;

   assign raw_in = {undervoltage_reset_in_n, battery_undervoltage_threshold,
                    vcc_undervoltage, local_wake_input, bus_prewake_threshold,
                    bus_level, txd_in, enable_pin, low_side_control_in};

   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               meta_q[gi] <= 1'(`SYNC_RESET >> gi);
               sync_q[gi] <= 1'(`SYNC_RESET >> gi);
            end else begin
               meta_q[gi] <= raw_in[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   wire logic [1:0] ls_s = sync_q[1:0];
   wire logic en_s = sync_q[2];
   wire logic txd_s = sync_q[3];
   wire logic bus_s = sync_q[4];
   wire logic prewake_s = sync_q[5];
   wire logic wake_pin_s = sync_q[6];
   wire logic vcc_uv_s = sync_q[7];
   wire logic batt_uv_s = sync_q[8];
   wire logic undervoltage_reset_out_n_pin_s = sync_q[9];

   // ----------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------
   mode_e mode_q, mode_d;
   source_e src_q, src_d;
   logic [`TMR_W-1:0] rst_cnt_q, rst_cnt_d;
   logic [`TMR_W-1:0] dom_cnt_q, dom_cnt_d;
   logic [`TMR_W-1:0] sel_cnt_q, sel_cnt_d;
   logic [`WT_FIELD_W-1:0] bus_cnt_q, bus_cnt_d;
   logic [`WT_FIELD_W-1:0] lw_cnt_q, lw_cnt_d;
   logic sel_busy_q, sel_busy_d;
   logic en_prev_q, bus_prev_q;
   logic [31:0] wake_time_q;
   logic start_rst;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire logic rst_busy = (rst_cnt_q != '0);
   wire logic en_fall = en_prev_q & ~en_s;
   wire logic bus_rise = bus_s & ~bus_prev_q;
   wire logic is_sleep = (mode_q == MODE_SLEEP);
   wire logic is_silent = (mode_q == MODE_SILENT);
   wire logic is_normal = (mode_q == MODE_NORMAL);
   wire logic is_fs = (mode_q == MODE_FAILSAFE);
   wire logic dormant = is_sleep | is_silent;
   wire logic [`WT_FIELD_W-1:0] bus_wake_lim =
      wake_time_q[`WT_BUS_LSB +: `WT_FIELD_W];
   wire logic [`WT_FIELD_W-1:0] lw_wake_lim =
      wake_time_q[`WT_LOCAL_LSB +: `WT_FIELD_W];
   wire logic tx_timeout = (dom_cnt_q == `TMR_W'(DOM_CYCLES));
   // own sleep drive is not a reset cause, the pin read back would loop
   wire logic undervoltage_reset_out_n_low = (rst_busy | ~undervoltage_reset_out_n_pin_s) & ~is_sleep;
   wire logic sel_end = sel_busy_q &
      (sel_cnt_q == `TMR_W'(`SEL_WINDOW_CYCLES));
   // txd sampled at the end of the window so a late txd fall still counts
   wire logic sel_fire = sel_end & ~rst_busy;
   wire logic bus_wake = dormant & bus_rise &
      (bus_cnt_q >= bus_wake_lim) & (~is_silent | txd_s);
   wire logic local_wake = dormant & (lw_cnt_q == lw_wake_lim);

   // ----------------------------------------------------------------
   // mode select window
   // ----------------------------------------------------------------
   always_comb begin
      sel_busy_d = sel_busy_q;
      sel_cnt_d = sel_cnt_q;
      if (en_fall & ~rst_busy) begin
         sel_busy_d = 1'b1;
         sel_cnt_d = '0;
      end else if (sel_end | en_s) begin
         sel_busy_d = 1'b0;
      end else if (sel_busy_q) begin
         sel_cnt_d = sel_cnt_q + `TMR_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // wake filters and txd dominant timeout
   // ----------------------------------------------------------------
   always_comb begin
      bus_cnt_d = '0;
      lw_cnt_d = '0;
      dom_cnt_d = '0;
      if (dormant & prewake_s & ~bus_s) begin
         bus_cnt_d = (bus_cnt_q == '1) ? bus_cnt_q
                                       : bus_cnt_q + `WT_FIELD_W'(1);
      end
      if (dormant & ~wake_pin_s) begin
         // stops one past the limit so a held pin wakes only once
         lw_cnt_d = (lw_cnt_q > lw_wake_lim) ? lw_cnt_q
                                            : lw_cnt_q + `WT_FIELD_W'(1);
      end
      if (is_normal & ~txd_s) begin
         dom_cnt_d = tx_timeout ? dom_cnt_q : dom_cnt_q + `TMR_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // mode state machine
   // ----------------------------------------------------------------
   always_comb begin
      mode_d = mode_q;
      src_d = src_q;
      start_rst = 1'b0;
      case (mode_q)
         MODE_FAILSAFE: begin
            // a held battery dip with enable high would bounce every cycle
            if (!rst_busy && en_s && !batt_uv_s) begin
               mode_d = MODE_NORMAL;
            end else if (sel_fire && src_q == SRC_BATTERY) begin
               mode_d = txd_s ? MODE_SILENT : MODE_SLEEP;
            end
         end
         MODE_NORMAL: begin
            src_d = SRC_NONE;
            if (vcc_uv_s) begin
               start_rst = 1'b1;
               mode_d = MODE_FAILSAFE;
            end else if (batt_uv_s) begin
               src_d = SRC_BATTERY;
               mode_d = MODE_FAILSAFE;
            end else if (sel_fire) begin
               // a stuck-low txd still lands here after the timeout
               mode_d = txd_s ? MODE_SILENT : MODE_SLEEP;
            end
         end
         MODE_SILENT: begin
            if (vcc_uv_s) begin
               start_rst = 1'b1;
               mode_d = MODE_FAILSAFE;
            end else if (bus_wake) begin
               src_d = SRC_BUS;
               mode_d = MODE_FAILSAFE;
            end else if (local_wake) begin
               src_d = SRC_LOCAL;
               mode_d = MODE_FAILSAFE;
            end
         end
         MODE_SLEEP: begin
            // regulator restarts, so the host sees a full reset pulse
            if (bus_wake) begin
               src_d = SRC_BUS;
               start_rst = 1'b1;
               mode_d = MODE_FAILSAFE;
            end else if (local_wake) begin
               src_d = SRC_LOCAL;
               start_rst = 1'b1;
               mode_d = MODE_FAILSAFE;
            end
         end
         default: begin
            mode_d = MODE_FAILSAFE;
         end
      endcase
      if (undervoltage_reset_out_n_low && mode_d != MODE_SLEEP) begin
         mode_d = MODE_FAILSAFE;
      end
   end

   always_comb begin
      rst_cnt_d = rst_busy ? rst_cnt_q - `TMR_W'(1) : rst_cnt_q;
      if (start_rst) begin
         rst_cnt_d = `TMR_W'(RESET_CYCLES);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode_q <= MODE_FAILSAFE;
         src_q <= SRC_NONE;
         rst_cnt_q <= `TMR_W'(RESET_CYCLES);
         sel_busy_q <= 1'b0;
         sel_cnt_q <= '0;
         bus_cnt_q <= '0;
         lw_cnt_q <= '0;
         dom_cnt_q <= '0;
         en_prev_q <= 1'b0;
         bus_prev_q <= 1'b1;
      end else begin
         mode_q <= mode_d;
         src_q <= src_d;
         rst_cnt_q <= rst_cnt_d;
         sel_busy_q <= sel_busy_d;
         sel_cnt_q <= sel_cnt_d;
         bus_cnt_q <= bus_cnt_d;
         lw_cnt_q <= lw_cnt_d;
         dom_cnt_q <= dom_cnt_d;
         en_prev_q <= en_s;
         bus_prev_q <= bus_s;
      end
   end

   // ----------------------------------------------------------------
   // pin and front-end outputs
   // ----------------------------------------------------------------
   wire logic fs_txd = (src_q == SRC_BATTERY) | (src_q == SRC_NONE);
   wire logic fs_rxd = (src_q == SRC_LOCAL) | (src_q == SRC_NONE);
   wire logic rxd_d = is_normal ? bus_s : (is_silent | (is_fs & fs_rxd));
   wire logic undervoltage_reset_out_n_drive = rst_busy | is_sleep;
   wire logic tx_ok = is_normal & ~tx_timeout;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         transceiver_tx_enable <= 1'b0;
         transceiver_rx_enable <= 1'b0;
         bus_drive_dominant <= 1'b0;
         bus_receiver_enable <= 1'b0;
         slave_termination_enable <= 1'b1;
         weak_pullup_enable <= 1'b0;
         regulator_enable <= 1'b1;
         low_side_out <= 2'h0;
         rxd <= 1'b1;
         txd_out <= 1'b1;
         txd_oe <= 1'b1;
         undervoltage_reset_out_n <= 1'b0;
         undervoltage_reset_oe <= 1'b1;
      end else begin
         transceiver_tx_enable <= tx_ok;
         transceiver_rx_enable <= is_normal;
         bus_drive_dominant <= tx_ok & ~txd_s;
         bus_receiver_enable <= is_normal | (dormant & prewake_s);
         slave_termination_enable <= is_normal | is_fs;
         weak_pullup_enable <= dormant;
         regulator_enable <= ~is_sleep;
         low_side_out <= is_normal ? ls_s : 2'h0;
         rxd <= rxd_d;
         txd_out <= fs_txd;
         txd_oe <= is_fs;
         undervoltage_reset_out_n <= 1'b0;
         undervoltage_reset_oe <= undervoltage_reset_out_n_drive;
      end
   end

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   wire logic req = cyc_i & stb_i;
   wire logic hit_status = (adr_i == `REG_STATUS);
   wire logic hit_wake = (adr_i == `REG_WAKE_TIME);
   logic [31:0] status_word;
   logic [31:0] rd_word;

   always_comb begin
      status_word = 32'h0;
      status_word[`ST_MODE_LSB +: 2] = mode_q;
      status_word[`ST_SRC_LSB +: 2] = src_q;
      status_word[`ST_RST_BIT] = rst_busy;
      status_word[`ST_TMO_BIT] = tx_timeout;
      rd_word = hit_status ? status_word : (hit_wake ? wake_time_q : 32'h0);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= req & ~ack_o;
         dat_o <= (req & ~ack_o) ? rd_word : 32'h0;
      end
   end

   // write lands on the edge at which the master samples ack
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               wake_time_q[gi*8 +: 8] <= 8'(`WAKE_TIME_RESET >> (gi*8));
            end else if (req && ack_o && we_i && hit_wake && sel_i[gi]) begin
               wake_time_q[gi*8 +: 8] <= dat_i[gi*8 +: 8];
            end
         end
      end
   endgenerate

endmodule // lin_sbc_mode_controller

// >>> mode_ctrl_asserts.sv
// concurrent checks on the mode controller pins
`timescale 1ns/1ps
module mode_ctrl_checker #(
   parameter int unsigned RESET_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic enable_pin,
   input wire logic vcc_undervoltage,
   input wire logic battery_undervoltage_threshold,
   input wire logic undervoltage_reset_in_n,
   input wire logic undervoltage_reset_oe,
   input wire logic txd_oe,
   input wire logic rxd,
   input wire logic [1:0] low_side_out,
   input wire logic transceiver_tx_enable,
   input wire logic transceiver_rx_enable,
   input wire logic bus_drive_dominant,
   input wire logic slave_termination_enable,
   input wire logic weak_pullup_enable,
   input wire logic regulator_enable
);
   // --------------------
   // reset pulse length
   // --------------------
   int hi_q;
   // sleep holds the wire low with the regulator off, so it is not counted
   always_ff @(posedge core_clk or posedge reset)
      if (reset) hi_q <= 0;
      else if (undervoltage_reset_oe && regulator_enable) hi_q <= hi_q + 1;
      else hi_q <= 0;

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   a_low_side_gate: assert property (
      (low_side_out != 2'b00) |-> transceiver_rx_enable)
      else $error("low side driven outside normal");
   a_sleep_outputs: assert property (
      !regulator_enable |-> !rxd && undervoltage_reset_oe &&
         !slave_termination_enable && !transceiver_tx_enable)
      else $error("sleep outputs wrong");
   a_silent_outputs: assert property (
      weak_pullup_enable && regulator_enable |->
         !slave_termination_enable && !transceiver_tx_enable)
      else $error("silent outputs wrong");
   a_drive_normal: assert property (
      bus_drive_dominant |-> transceiver_tx_enable && regulator_enable)
      else $error("bus driven outside normal");
   a_txd_drive_fs: assert property (
      txd_oe |-> !transceiver_rx_enable && !transceiver_tx_enable)
      else $error("txd driven outside fail-safe");
   a_wire_low_fs: assert property (
      !undervoltage_reset_in_n && regulator_enable |->
         ##[0:5] (txd_oe && !transceiver_rx_enable))
      else $error("reset wire low without fail-safe");
   a_vcc_uv_reset: assert property (
      vcc_undervoltage && transceiver_rx_enable |->
         ##[1:6] undervoltage_reset_oe)
      else $error("undervoltage without reset");
   a_fs_to_normal: assert property (
      $rose(enable_pin) && txd_oe && !undervoltage_reset_oe &&
         undervoltage_reset_in_n && !vcc_undervoltage &&
         !battery_undervoltage_threshold |-> ##[2:8] transceiver_rx_enable)
      else $error("enable high did not give normal");
   a_reset_length: assert property (
      $fell(undervoltage_reset_oe) |->
         hi_q >= RESET_CYCLES - 2 && hi_q <= RESET_CYCLES + 8)
      else $error("reset pulse length wrong");
endmodule // mode_ctrl_checker

bind lin_sbc_mode_controller mode_ctrl_checker #(
   .RESET_CYCLES(RESET_CYCLES)
) u_chk (
   .core_clk, .reset, .enable_pin, .vcc_undervoltage,
   .battery_undervoltage_threshold, .undervoltage_reset_in_n,
   .undervoltage_reset_oe, .txd_oe, .rxd, .low_side_out,
   .transceiver_tx_enable, .transceiver_rx_enable, .bus_drive_dominant,
   .slave_termination_enable, .weak_pullup_enable, .regulator_enable
);

// >>> host_mcu_model.sv
// host microcontroller driving the enable and transmit pins
`timescale 1ns/1ps
module host_mcu_model (
   input wire logic core_clk,
   output logic en,
   output logic txd,
   output logic txd_oe
);
   // --------------------
   // pin drive
   // --------------------
   initial begin
      en = 1'b0;
      txd = 1'b1;
      txd_oe = 1'b1;
   end
   task drive(input logic e, input logic t, input logic oe);
      @(posedge core_clk);
      en <= e;
      txd <= t;
      txd_oe <= oe;
   endtask
   // enable may lead txd by up to 3.2 us; lead is kept under 320 cycles
   task mode_req(input logic tl, input int lead);
      drive(1'b0, (lead > 0) ? 1'b1 : tl, 1'b1);
      repeat (lead) @(posedge core_clk);
      txd <= tl;
      repeat (400) @(posedge core_clk);
   endtask
endmodule // host_mcu_model

// >>> testbench.sv
// self-checking bench for the mode controller
`timescale 1ns/1ps
module testbench;
   localparam int RST = 50;
   logic core_clk = 0, reset = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, txd_out, txd_oe, rxd, rst_n, rst_oe, ext_low = 0;
   logic bus_lvl = 1, prewake = 0, wake_n = 1, vcc_uv = 0, bat_uv = 0;
   logic [1:0] ls_in = 2'b00, ls_out;
   logic tx_en, rx_en, dom, brx_en, term, pu, reg_en, en, h_txd, h_oe;
   // device drive wins; a released line flips so a stale level is not seen
   wire txd_w = txd_oe ? txd_out : (h_oe ? h_txd : ~h_txd);
   wire rst_w = ~(rst_oe | ext_low);
   int fails = 0, checks = 0;
   // {tx, rx, term, pullup, regulator, txd_oe, reset_oe} per mode
   int exp_tab[4] = '{7'h16, 7'h74, 7'h0C, 7'h09};

   always #5 core_clk = ~core_clk;

   lin_sbc_mode_controller #(.RESET_CYCLES(RST), .DOM_CYCLES(100))
   u_lin_sbc_mode_controller (
      .core_clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .enable_pin(en), .txd_in(txd_w), .txd_out,
      .txd_oe, .rxd, .undervoltage_reset_in_n(rst_w),
      .undervoltage_reset_out_n(rst_n), .undervoltage_reset_oe(rst_oe),
      .low_side_control_in(ls_in), .low_side_out(ls_out),
      .bus_level(bus_lvl), .bus_prewake_threshold(prewake),
      .local_wake_input(wake_n), .vcc_undervoltage(vcc_uv),
      .battery_undervoltage_threshold(bat_uv),
      .transceiver_tx_enable(tx_en), .transceiver_rx_enable(rx_en),
      .bus_drive_dominant(dom), .bus_receiver_enable(brx_en),
      .slave_termination_enable(term), .weak_pullup_enable(pu),
      .regulator_enable(reg_en));
   host_mcu_model u_host_mcu_model (
      .core_clk, .en, .txd(h_txd), .txd_oe(h_oe));

   // --------------------
   // helpers
   // --------------------
   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task chk_mode(input int md);
      chk("outputs", exp_tab[md], {tx_en, rx_en, term, pu, reg_en, txd_oe, rst_oe});
      if (md != 1) chk("low side", 0, ls_out);
      if (md >= 2) chk("rxd", md == 2, rxd);
   endtask
   task wb(input logic w, input logic [3:0] s, input logic [3:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      sel_i <= s;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      if (n >= 50) chk("ack", 1, 0);
   endtask
   task test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      tick(20000);
      fails++;
      test_done;
   end

   // --------------------
   // scenarios
   // --------------------
   initial begin
      void'($urandom(32'h57CC1B11));
      tick(5);
      reset <= 0;
      tick(2);
      chk("reset out", 1, rst_oe);
      chk("reset level", 0, rst_n);
      tick(RST + 10);
      chk_mode(0);
      chk("code", 2'b11, {txd_out, rxd});
      wb(0, 4'hF, 4'h4, 0);
      chk("wake time", 32'h2710_2710, rd);
      wb(1, 4'hF, 4'h4, 32'h0008_0010);
      wb(1, 4'hC, 4'h4, 32'h0007_FFFF);
      wb(0, 4'hF, 4'h4, 0);
      chk("wake time", 32'h0007_0010, rd);
      wb(1, 4'hF, 4'h0, 32'hFFFF_FFFF);
      wb(0, 4'hF, 4'h0, 0);
      chk("status", 0, rd);
      wb(0, 4'hF, 4'h8, 0);
      chk("unmapped", 0, rd);
      u_host_mcu_model.drive(1, 1, 1);
      tick(10);
      chk_mode(1);
      repeat (4) begin
         ls_in <= 2'($urandom);
         tick(6);
         chk("low side", ls_in, ls_out);
      end
      u_host_mcu_model.drive(1, 0, 1);
      tick(6);
      chk("dominant", 1, dom);
      u_host_mcu_model.drive(1, 1, 1);
      tick(6);
      chk("dominant", 0, dom);
      ls_in <= 2'b11;
      u_host_mcu_model.mode_req(1, 0);
      chk_mode(2);
      wake_n <= 0;
      tick(20);
      wake_n <= 1;
      tick(5);
      chk_mode(0);
      chk("code", 2'b01, {txd_out, rxd});
      u_host_mcu_model.drive(1, 1, 1);
      tick(10);
      chk_mode(1);
      wb(0, 4'hF, 4'h0, 0);
      chk("source", 0, rd[3:2]);
      u_host_mcu_model.mode_req(0, $urandom_range(300));
      chk_mode(3);
      prewake <= 1;
      tick(6);
      chk("receiver", 1, brx_en);
      bus_lvl <= 0;
      tick(40);
      bus_lvl <= 1;
      prewake <= 0;
      tick(6);
      chk("bus wake", 4'b1001, {txd_oe, txd_out, rxd, rst_oe});
      chk("reset level", 0, rst_n);
      u_host_mcu_model.drive(1, 1, 1);
      tick(RST + 10);
      chk_mode(1);
      vcc_uv <= 1;
      tick(4);
      vcc_uv <= 0;
      tick(4);
      chk("uv reset", 2'b11, {rst_oe, txd_oe});
      tick(RST + 10);
      chk_mode(1);
      ext_low <= 1;
      tick(6);
      chk_mode(0);
      ext_low <= 0;
      tick(10);
      chk_mode(1);
      u_host_mcu_model.drive(1, 0, 1);
      tick(150);
      chk("tx enable", 0, tx_en);
      u_host_mcu_model.mode_req(0, 0);
      chk_mode(3);
      wake_n <= 0;
      tick(20);
      wake_n <= 1;
      u_host_mcu_model.drive(1, 1, 1);
      tick(RST + 10);
      chk_mode(1);
      bat_uv <= 1;
      tick(6);
      chk_mode(0);
      chk("code", 2'b10, {txd_out, rxd});
      u_host_mcu_model.mode_req(1, 0);
      chk_mode(2);
      bat_uv <= 0;
      test_done;
   end
endmodule // testbench
